// ==== core/ram_params.svh ====
// Constants for the embedded RAM block family.
`ifndef RAM_PARAMS_SVH
`define RAM_PARAMS_SVH
`define SMALL_BITS 576
`define MEDIUM_BITS 4608
`define LARGE_BITS 589824
`define SMALL_MAX_W 18
`define MEDIUM_MAX_W 36
`define LARGE_MAX_W 144
`define SMALL_AW 9
`define MEDIUM_AW 12
`define LARGE_AW 16
`define MAX_W 144
`define MAX_AW 16
`define VARIANT_SMALL 2'h0
`define VARIANT_MEDIUM 2'h1
`define VARIANT_LARGE 2'h2
`endif

// ==== core/ram_pkg.sv ====
// Types for the embedded RAM block family.
`default_nettype none
package ram_pkg;
  typedef enum logic [1:0] {
    VAR_SMALL = 2'h0,
    VAR_MEDIUM = 2'h1,
    VAR_LARGE = 2'h2
  } variant_e;
  typedef enum logic {
    MODE_SIMPLE = 1'h0,
    MODE_TRUE = 1'h1
  } port_mode_e;
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [143:0] data;
  } port_req_s;
endpackage
`default_nettype wire

// ==== core/ram_block.sv ====
// Parameterised synchronous RAM block, small, medium or large variant.
//
// Overview of operation
// - The block is built as the small, medium or large variant from a single parameterised module.
// - The small variant offers 512x1, 256x2, 128x4, 64x8, 64x9, 32x16 and 32x18.
// - The medium variant offers 4Kx1, 2Kx2, 1Kx4, 512x8, 512x9, 256x16, 256x18, 128x32 and 128x36.
// - The large variant offers 64Kx8, 64Kx9, 32Kx16, 32Kx18, 16Kx32, 16Kx36, 8Kx64, 8Kx72, 4Kx128 and 4Kx144.
// - Each variant works with plain power-of-two widths and with nine-bit parity widths.
// - In simple dual-port form the read and write ports may have different widths.
// - Only medium and large variants offer true dual-port form, with mixed widths allowed.
// - The large variant has no preloaded contents.
// - With the output register in place, clearing input registers shows at the output after the next edge; clearing output registers shows at once.
// - Large variant inputs are all registered, the output register is bypassable, contents power up undefined.
`timescale 1ns/1ps
`default_nettype none
`include "ram_params.svh"
module ram_block #(
  parameter ram_pkg::variant_e VARIANT = ram_pkg::VAR_MEDIUM,
  parameter ram_pkg::port_mode_e MODE = ram_pkg::MODE_SIMPLE,
  parameter int WIDTH_A = 36,
  parameter int WIDTH_B = 36,
  parameter bit OUT_REG_B = 1'b1,
  parameter bit OUT_REG_A = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_clr,
  input wire logic out_clr,
  input wire ram_pkg::port_req_s req_a,
  input wire ram_pkg::port_req_s req_b,
  output var logic [`MAX_W-1:0] q_a,
  output var logic [`MAX_W-1:0] q_b,
  output var logic cfg_error
);
  // variant geometry select
  // Storage geometry per variant; MAX_W is the widest legal shape.
  localparam int MAX_W = (VARIANT == ram_pkg::VAR_SMALL) ? `SMALL_MAX_W :
                         (VARIANT == ram_pkg::VAR_MEDIUM) ? `MEDIUM_MAX_W : `LARGE_MAX_W;
  localparam int TOT_BITS = (VARIANT == ram_pkg::VAR_SMALL) ? `SMALL_BITS :
                            (VARIANT == ram_pkg::VAR_MEDIUM) ? `MEDIUM_BITS : `LARGE_BITS;
  localparam int NARROW_MIN = (VARIANT == ram_pkg::VAR_LARGE) ? 8 : 1;

  // Shape legality check.
  function automatic bit legal_width(input int w);
    bit ok;
    ok = 1'b0;
    if ((w % 9) == 0 && w >= 9 && w <= MAX_W && ((w / 9) & ((w / 9) - 1)) == 0) begin
      ok = 1'b1;
    end
    if (w >= NARROW_MIN && w <= (MAX_W / 9) * 8 && (w & (w - 1)) == 0) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  localparam bit MODE_OK = !(MODE == ram_pkg::MODE_TRUE && VARIANT == ram_pkg::VAR_SMALL);
  // mixed widths allowed, each legal on its own
  localparam bit SHAPE_OK = legal_width(WIDTH_A) && legal_width(WIDTH_B) && MODE_OK;
  // Mixing a parity width with a plain width would lose bits, so both must agree on parity.
  localparam bit PAR_A = (WIDTH_A % 9) == 0;
  localparam bit PAR_B = (WIDTH_B % 9) == 0;
  localparam bit CFG_OK = SHAPE_OK && (PAR_A == PAR_B);
  // Storage is kept at the narrowest legal granule of the chosen parity class.
  localparam int GW = PAR_A ? 9 : ((VARIANT == ram_pkg::VAR_LARGE) ? 8 : 1);
  localparam int STORE_BITS = PAR_A ? TOT_BITS : (TOT_BITS / 9) * 8;
  localparam int GRAN = STORE_BITS / GW;
  localparam int RA = WIDTH_A / GW;
  localparam int RB = WIDTH_B / GW;
  localparam int GAW = $clog2(GRAN);

  // no initial image, contents undefined at power-up
  logic [GW-1:0] mem [GRAN];

  ram_pkg::port_req_s a_reg;
  ram_pkg::port_req_s b_reg;
  logic [`MAX_W-1:0] rd_a_next;
  logic [`MAX_W-1:0] rd_b_next;
  logic [`MAX_W-1:0] q_a_reg;
  logic [`MAX_W-1:0] q_b_reg;
  logic cfg_error_reg;

  // Both clears are level-sensitive: a clear still high at an edge keeps its registers empty at that edge.
  // input clear acts at once on the registers
  always_ff @(posedge clk or posedge reset or posedge in_clr) begin
    if (reset || in_clr) begin
      a_reg <= '0;
      b_reg <= '0;
    end else begin
      a_reg <= req_a;
      b_reg <= req_b;
    end
  end

  // Port B writes only in true dual-port mode; in simple mode A is write, B is read.
  wire a_writes = a_reg.we && CFG_OK;
  wire b_writes = b_reg.we && CFG_OK && (MODE == ram_pkg::MODE_TRUE);
  wire [GAW-1:0] a_base = GAW'(a_reg.addr * RA);
  wire [GAW-1:0] b_base = GAW'(b_reg.addr * RB);

  // first write seen
  // Until a word has been written the array holds unknowns, so the hold check waits for this.
  logic any_write_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      any_write_reg <= 1'b0;
    end else if (a_writes || b_writes) begin
      any_write_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < RA; i++) begin
      if (a_writes) begin
        mem[GAW'(a_base + GAW'(i))] <= a_reg.data[i*GW +: GW];
      end
    end
    for (int i = 0; i < RB; i++) begin
      if (b_writes) begin
        mem[GAW'(b_base + GAW'(i))] <= b_reg.data[i*GW +: GW];
      end
    end
  end

  // reads see earlier writes next cycle
  always_comb begin
    rd_a_next = '0;
    rd_b_next = '0;
    for (int i = 0; i < RA; i++) begin
      rd_a_next[i*GW +: GW] = mem[GAW'(a_base + GAW'(i))];
    end
    for (int i = 0; i < RB; i++) begin
      rd_b_next[i*GW +: GW] = mem[GAW'(b_base + GAW'(i))];
    end
  end

  always_ff @(posedge clk or posedge reset or posedge out_clr) begin
    if (reset || out_clr) begin
      q_a_reg <= '0;
      q_b_reg <= '0;
    end else begin
      q_a_reg <= rd_a_next;
      q_b_reg <= rd_b_next;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_error_reg <= 1'b0;
    end else begin
      cfg_error_reg <= !CFG_OK;
    end
  end

  // A bypassed output follows the address register directly, so out_clr does not reach it.
  // output register bypass option
  assign q_a = OUT_REG_A ? q_a_reg : rd_a_next;
  assign q_b = OUT_REG_B ? q_b_reg : rd_b_next;
  assign cfg_error = cfg_error_reg;

  // Assertions.
  // write then read
  write_read_a: assert property (@(posedge clk) disable iff (reset || in_clr || out_clr)
    (a_writes && MODE == ram_pkg::MODE_SIMPLE && RA == RB ##1 (b_reg.addr == $past(a_reg.addr)))
    |=> (q_b_reg[WIDTH_B-1:0] == $past(a_reg.data[WIDTH_B-1:0], 2)))
    else $error("written word not read back");
  out_clear_a: assert property (@(posedge clk) disable iff (reset)
    out_clr |-> (q_a_reg == '0 && q_b_reg == '0))
    else $error("output clear not seen");
  in_clear_a: assert property (@(posedge clk) disable iff (reset)
    in_clr |-> (a_reg == '0 && b_reg == '0))
    else $error("input clear not seen");
  small_mode_a: assert property (@(posedge clk) disable iff (reset)
    ##1 (cfg_error_reg == !CFG_OK))
    else $error("configuration flag wrong");
  cfg_block_a: assert property (@(posedge clk) disable iff (reset)
    cfg_error_reg |-> (!a_writes && !b_writes))
    else $error("write with illegal configuration");
  simple_bwr_a: assert property (@(posedge clk) disable iff (reset)
    (MODE == ram_pkg::MODE_SIMPLE) |-> !b_writes)
    else $error("port B wrote in simple mode");
  input_reg_a: assert property (@(posedge clk) disable iff (reset)
    (!reset && !in_clr ##1 !in_clr) |-> (a_reg == $past(req_a)))
    else $error("input not registered");
  b_capture_a: assert property (@(posedge clk) disable iff (reset)
    (!reset && !in_clr ##1 !in_clr) |-> (b_reg == $past(req_b)))
    else $error("port B input not registered");
  rom_hold_a: assert property (@(posedge clk) disable iff (reset)
    (any_write_reg && !a_reg.we && !b_reg.we) |=> (mem[$past(a_base)] == $past(mem[a_base])))
    else $error("memory changed with writes off");
  width_ok_a: assert property (@(posedge clk) disable iff (reset)
    CFG_OK |-> (WIDTH_A <= MAX_W && WIDTH_B <= MAX_W))
    else $error("width above maximum");

  // Cover points for the main scenarios.
  // table write
  write_cov: cover property (@(posedge clk) a_writes);
  read_cov: cover property (@(posedge clk) a_writes ##1 !a_writes);
  clear_cov: cover property (@(posedge clk) out_clr);
  in_clear_cov: cover property (@(posedge clk) in_clr);
  rom_idle_cov: cover property (@(posedge clk) any_write_reg && !a_reg.we);
endmodule // ram_block
`default_nettype wire

// ==== verification/table_loader.sv ====
// Partner model: fabric logic that loads a table once, then treats the block as read-only.
`timescale 1ns/1ps
`default_nettype none
module table_loader (
  input wire logic clk,
  input wire logic reset,
  output var ram_pkg::port_req_s req,
  output var logic done
);
  logic [3:0] cnt_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 4'h0;
      req <= '0;
      done <= 1'b0;
    end else if (cnt_reg < 4'h8) begin
      req.we <= 1'b1;
      req.addr <= {12'h000, cnt_reg};
      req.data <= 144'(36'h9a5c3 + 36'(cnt_reg) * 36'h111);
      cnt_reg <= cnt_reg + 4'h1;
    end else begin
      req.we <= 1'b0;
      // Idle data keeps changing so that a leaked write cannot go unnoticed.
      req.data <= ~req.data;
      done <= 1'b1;
    end
  end
endmodule // table_loader
`default_nettype wire

// ==== verification/test_ram_block.sv ====
// Self-checking bench for the medium RAM variant in simple dual-port form.
`timescale 1ns/1ps
`default_nettype none
module test_ram_block;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic in_clr = 1'b0;
  logic out_clr = 1'b0;
  logic done;
  ram_pkg::port_req_s req_a;
  ram_pkg::port_req_s req_b = '0;
  logic [143:0] q_a;
  logic [143:0] q_b;
  logic cfg_error;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  table_loader loader (.clk(clk), .reset(reset), .req(req_a), .done(done));
  ram_block #(.VARIANT(ram_pkg::VAR_MEDIUM), .MODE(ram_pkg::MODE_SIMPLE), .WIDTH_A(36), .WIDTH_B(36)) dut (
    .clk(clk), .reset(reset), .in_clr(in_clr), .out_clr(out_clr), .req_a(req_a), .req_b(req_b),
    .q_a(q_a), .q_b(q_b), .cfg_error(cfg_error));
  task automatic check(input logic [143:0] seen, input logic [143:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [143:0] entry(input int k);
    return 144'(36'h9a5c3 + 36'(k) * 36'h111);
  endfunction
  // Read latency is two edges from address to q with the output register in place.
  task automatic read_b(input int k);
    @(posedge clk);
    req_b.addr <= 16'(k);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic test_readback();
    for (int k = 0; k < 8; k++) begin
      read_b(k);
      check(q_b, entry(k));
    end
  endtask
  task automatic test_in_clr();
    read_b(5);
    @(posedge clk);
    in_clr <= 1'b1;
    #1;
    check(q_b, entry(5));
    check(q_a, entry(7));
    @(posedge clk);
    in_clr <= 1'b0;
    #1;
    check(q_b, entry(0));
    check(q_a, entry(0));
  endtask
  task automatic test_out_clr();
    read_b(3);
    @(posedge clk);
    out_clr <= 1'b1;
    #1;
    check(q_b, 144'h0);
    check(q_a, 144'h0);
    @(posedge clk);
    out_clr <= 1'b0;
    read_b(3);
    check(q_b, entry(3));
    check(q_a, entry(7));
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 400) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    while (done !== 1'b1) @(posedge clk);
    check(144'(cfg_error), 144'h0);
    test_readback();
    test_in_clr();
    test_out_clr();
    conclude();
  end
endmodule // test_ram_block
`default_nettype wire
